/* src/mhi_pkg.sv */
// Package: register map, field layouts and timing constants
package mhi_pkg;
  localparam logic [7:0] ADDR_CLK_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_CMD_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_BLK_LEN    = 8'h20;
  localparam logic [7:0] ADDR_BLK_COUNT  = 8'h24;
  localparam logic [7:0] ADDR_INT_SRC    = 8'h28;
  localparam logic [7:0] ADDR_INT_CLEAR  = 8'h2c;
  localparam logic [7:0] ADDR_INT_EN     = 8'h34;
  localparam logic [7:0] ADDR_EVENT_IN   = 8'h50;
  localparam logic [7:0] ADDR_DATA_LEFT  = 8'h54;

  // Interrupt source bit positions
  localparam int SRC_CMD_END  = 0;
  localparam int SRC_PROGRAM_DONE = 1;
  localparam int SRC_XFER_END = 2;
  localparam int SRC_CLK_STOP = 3;
  localparam int NUM_SRC      = 4;

  // Status bit positions
  localparam int ST_CMD_END   = 13;
  localparam int ST_PROGRAM_DONE  = 12;
  localparam int ST_XFER_END  = 11;
  localparam int ST_CLK_STOP  = 8;
  localparam int ST_FIFO_RDY  = 6;

  // Command control bit positions
  localparam int CC_FMT_LSB   = 0;
  localparam int CC_DATA_EN   = 2;
  localparam int CC_WRITE     = 3;
  localparam int CC_STREAM    = 4;
  localparam int CC_BUSY      = 5;
  localparam int CC_INIT      = 6;
  localparam logic [1:0] FMT_R1 = 2'h1;

  localparam logic [31:0] STATUS_RST  = 32'h0000_0140;
  localparam logic [15:0] BLK_LEN_RST = 16'h0200;
  localparam logic [7:0]  WAIT_CYC    = 8'h08;
  localparam logic [7:0]  INIT_CYC    = 8'h50;
  localparam logic [7:0]  CMD_CYC     = 8'h30;
  localparam logic [15:0] STREAM_TAIL = 16'h0006;

  typedef enum logic [2:0] {
    ST_IDLE, ST_INIT, ST_CMD, ST_DATA, ST_BUSY, ST_WAIT
  } mhi_phase_e;

  typedef enum logic [1:0] {W_IDLE, W_RESP} mhi_bus_e;

  typedef struct packed {
    mhi_bus_e    wph;
    logic        awok;
    logic        wok;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        arready;
    mhi_phase_e  ph;
    logic        running;
    logic [7:0]  cnt;
    logic [6:0]  cmd_ctrl;
    logic [15:0] blk_len;
    logic [15:0] blk_cnt;
    logic [15:0] left;
    logic [NUM_SRC-1:0] src;
    logic [NUM_SRC-1:0] en;
    logic        fifo_rdy;
    logic        irq;
    logic        clk_out;
    logic [2:0]  busy_sync;
    logic        busy_q;
    logic        crc_on;
  } mhi_state_s;
endpackage

/* src/mhi_core.sv */
// Interrupt and sequencing core of a card host with an AXI4-Lite slave
// Overview of operation
// - No-data command raises command-ended eight bus clocks after exchange ends.
// - Program-done flag and interrupt rise when card releases busy.
// - Each source enabled by its own enable bit; masked sources stay off output.
// - Writing one to a clear bit deasserts that source; zero leaves it.
// - One combined interrupt line; source and status registers readable.
// - Four sources mirror status flags of same meaning.
// - Clock-stopped source ignores clear; follows stopped clock.
// - Initialize field sends 80 bus clocks before the command.
// - Format 1 is R1; data-enable, write and stream fields select transfer.
// - Multiple block read stops bus clock after final block.
// - In stream write, device stops clock before last six bytes; software then restarts.
// - Stream transfers neither generate nor check data CRC.
// - Stop-clock write returns status and source registers to reset.
// - After busy ends per block, wait eight bus clocks before FIFO ready; the core waits for busy after a write's final block or when the busy field is set.
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
module mhi_core
  import mhi_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        card_busy,
  output logic             card_bus_clock,
  output logic             crc_active,
  output logic             card_host_irq_out
);
  mhi_state_s  st_ff;
  mhi_state_s  nxt_st;
  logic        wr_go;
  logic        bus_edge;
  logic        busy_s;
  logic [31:0] status_w;

  // Bus clock toggles each system clock while running; a falling edge of
  // the generated clock counts as one bus clock cycle.
  assign bus_edge = st_ff.running && st_ff.clk_out;
  assign busy_s   = st_ff.busy_sync[2];
  assign wr_go    = st_ff.wph == W_IDLE && st_ff.awok && st_ff.wok;

  always_comb begin
    status_w = STATUS_RST;
    status_w[ST_CMD_END]  = st_ff.src[SRC_CMD_END];
    status_w[ST_PROGRAM_DONE] = st_ff.src[SRC_PROGRAM_DONE];
    status_w[ST_XFER_END] = st_ff.src[SRC_XFER_END];
    status_w[ST_CLK_STOP] = !st_ff.running;
    status_w[ST_FIFO_RDY] = st_ff.fifo_rdy;
  end

  always_comb begin
    nxt_st = st_ff;
    // Busy pin from the card: three stages, accepted once 2nd and 3rd agree
    nxt_st.busy_sync = {st_ff.busy_sync[1:0], card_busy};
    if (st_ff.busy_sync[2] == st_ff.busy_sync[1]) begin
      nxt_st.busy_q = st_ff.busy_sync[2];
    end
    nxt_st.clk_out = st_ff.running ? !st_ff.clk_out : 1'b0;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && !st_ff.awok && st_ff.wph == W_IDLE) begin
      nxt_st.awok  = 1'b1;
      nxt_st.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.wok && st_ff.wph == W_IDLE) begin
      nxt_st.wok   = 1'b1;
      nxt_st.wdata = s_axi_wdata;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
      nxt_st.wph    = W_IDLE;
    end

    // Sequencer
    case (st_ff.ph)
      ST_IDLE: begin
        nxt_st.cnt = 8'h00;
      end
      ST_INIT: if (bus_edge) begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
        if (st_ff.cnt == INIT_CYC - 8'h01) begin
          nxt_st.ph  = ST_CMD;
          nxt_st.cnt = 8'h00;
        end
      end
      ST_CMD: if (bus_edge) begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
        if (st_ff.cnt == CMD_CYC - 8'h01) begin
          nxt_st.cnt = 8'h00;
          if (st_ff.cmd_ctrl[CC_DATA_EN]) begin
            nxt_st.ph = ST_DATA;
          end else begin
            nxt_st.ph = ST_WAIT;
          end
        end
      end
      ST_DATA: if (bus_edge) begin
        // Stream carries no CRC; block mode appends and checks one
        nxt_st.crc_on = !st_ff.cmd_ctrl[CC_STREAM];
        nxt_st.cnt = st_ff.cnt + 8'h01;
        if (st_ff.cnt == 8'hff) begin
          nxt_st.left = st_ff.left - 16'h0001;
        end
        if (st_ff.cmd_ctrl[CC_STREAM] && st_ff.cmd_ctrl[CC_WRITE] &&
            st_ff.left <= STREAM_TAIL) begin
          nxt_st.running = 1'b0;
          nxt_st.ph      = ST_IDLE;
          nxt_st.crc_on  = 1'b0;
        end else if (!st_ff.cmd_ctrl[CC_STREAM] && st_ff.cnt == 8'hff &&
                     st_ff.left == 16'h0001) begin
          nxt_st.crc_on = 1'b0;
          nxt_st.cnt    = 8'h00;
          if (st_ff.cmd_ctrl[CC_WRITE]) begin
            nxt_st.ph = ST_BUSY;
          end else begin
            nxt_st.ph = ST_WAIT;
          end
        end
      end
      ST_BUSY: begin
        // Busy must be seen first: the pin lags the sequencer by the sync,
        // so an idle pin on entry would otherwise end programming at once
        if (st_ff.busy_q) begin
          nxt_st.cnt = 8'hff;
        end else if (st_ff.cnt == 8'hff && !busy_s) begin
          nxt_st.src[SRC_PROGRAM_DONE] = 1'b1;
          nxt_st.ph  = ST_WAIT;
          nxt_st.cnt = 8'h00;
        end
      end
      ST_WAIT: if (bus_edge) begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
        if (st_ff.cnt == WAIT_CYC - 8'h01) begin
          nxt_st.ph = ST_IDLE;
          if (st_ff.cmd_ctrl[CC_BUSY]) begin
            nxt_st.ph  = ST_BUSY;
            nxt_st.cnt = 8'h00;
          end
          if (st_ff.cmd_ctrl[CC_DATA_EN]) begin
            nxt_st.src[SRC_XFER_END] = 1'b1;
            nxt_st.fifo_rdy          = 1'b1;
            if (!st_ff.cmd_ctrl[CC_WRITE]) begin
              nxt_st.running = 1'b0;
            end
          end else begin
            nxt_st.src[SRC_CMD_END] = 1'b1;
          end
        end
      end
      default: nxt_st.ph = ST_IDLE;
    endcase

    // Register writes; hardware set above wins over clear (set-wins)
    if (wr_go) begin
      nxt_st.awok   = 1'b0;
      nxt_st.wok    = 1'b0;
      nxt_st.wph    = W_RESP;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = 2'h0;
      case (st_ff.waddr)
        ADDR_CLK_CTRL: begin
          if (st_ff.wdata[0]) begin
            nxt_st.running  = 1'b0;
            nxt_st.ph       = ST_IDLE;
            nxt_st.src      = '0;
            // Empty buffers are the reset state of the FIFO flag
            nxt_st.fifo_rdy = 1'b1;
            nxt_st.crc_on   = 1'b0;
          end else if (st_ff.wdata[1]) begin
            nxt_st.running  = 1'b1;
            nxt_st.fifo_rdy = 1'b0;
            if (st_ff.ph == ST_IDLE && st_ff.cmd_ctrl[CC_DATA_EN] &&
                st_ff.left != 16'h0000 && st_ff.src[SRC_CMD_END]) begin
              nxt_st.ph = ST_DATA;                     // Resume after refill
            end else if (st_ff.ph == ST_IDLE) begin
              nxt_st.ph = st_ff.cmd_ctrl[CC_INIT] ? ST_INIT : ST_CMD;
              nxt_st.left = st_ff.blk_cnt;
            end
          end
        end
        ADDR_CMD_CTRL:  nxt_st.cmd_ctrl = st_ff.wdata[6:0];
        ADDR_BLK_LEN:   nxt_st.blk_len  = st_ff.wdata[15:0];
        ADDR_BLK_COUNT: nxt_st.blk_cnt  = st_ff.wdata[15:0];
        ADDR_DATA_LEFT: nxt_st.left     = st_ff.wdata[15:0];
        ADDR_INT_EN:    nxt_st.en       = st_ff.wdata[NUM_SRC-1:0];
        ADDR_INT_CLEAR: begin
          for (int i = 0; i < SRC_CLK_STOP; i++) begin
            if (st_ff.wdata[i] && !nxt_st.src[i]) begin
              nxt_st.src[i] = 1'b0;
            end else if (st_ff.wdata[i] && nxt_st.src[i] == st_ff.src[i]) begin
              nxt_st.src[i] = 1'b0;
            end
          end
        end
        default: nxt_st.bresp = 2'h2;
      endcase
    end
    nxt_st.src[SRC_CLK_STOP] = !nxt_st.running;

    // Read channel
    nxt_st.arready = !st_ff.rvalid && !st_ff.arready;
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid  = 1'b1;
      nxt_st.rresp   = 2'h0;
      case (s_axi_araddr)
        ADDR_STATUS:    nxt_st.rdata = status_w;
        ADDR_INT_SRC:   nxt_st.rdata = {28'h0, st_ff.src};
        ADDR_INT_EN:    nxt_st.rdata = {28'h0, st_ff.en};
        ADDR_CMD_CTRL:  nxt_st.rdata = {25'h0, st_ff.cmd_ctrl};
        ADDR_BLK_LEN:   nxt_st.rdata = {16'h0, st_ff.blk_len};
        ADDR_BLK_COUNT: nxt_st.rdata = {16'h0, st_ff.blk_cnt};
        ADDR_DATA_LEFT: nxt_st.rdata = {16'h0, st_ff.left};
        ADDR_CLK_CTRL,
        ADDR_INT_CLEAR: nxt_st.rdata = 32'h0;
        default: begin
          nxt_st.rdata = 32'h0;
          nxt_st.rresp = 2'h2;
        end
      endcase
    end

    // Registered so a glitch of the mask write never reaches the pin
    nxt_st.irq = |(st_ff.src & st_ff.en);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff          <= '0;
      st_ff.ph       <= ST_IDLE;
      st_ff.wph      <= W_IDLE;
      st_ff.blk_len  <= BLK_LEN_RST;
      st_ff.fifo_rdy <= 1'b1;
      st_ff.src      <= 4'h8;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready     = !st_ff.awok && st_ff.wph == W_IDLE;
  assign s_axi_wready      = !st_ff.wok && st_ff.wph == W_IDLE;
  assign s_axi_bvalid      = st_ff.bvalid;
  assign s_axi_bresp       = st_ff.bresp;
  assign s_axi_arready     = st_ff.arready;
  assign s_axi_rvalid      = st_ff.rvalid;
  assign s_axi_rdata       = st_ff.rdata;
  assign s_axi_rresp       = st_ff.rresp;
  assign card_bus_clock    = st_ff.clk_out;
  assign crc_active        = st_ff.crc_on;
  assign card_host_irq_out = st_ff.irq;

  property p_irq_mask;
    @(posedge aclk) disable iff (!aresetn)
      (st_ff.src & st_ff.en) == 4'h0 |=> !card_host_irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("Masked irq");

  property p_irq_set;
    @(posedge aclk) disable iff (!aresetn)
      (st_ff.src & st_ff.en) != 4'h0 |=> card_host_irq_out;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("Irq missing");

  property p_clkstop;
    @(posedge aclk) disable iff (!aresetn)
      st_ff.src[SRC_CLK_STOP] == !st_ff.running;
  endproperty
  a_clkstop: assert property (p_clkstop) else $error("Clk src");

  property p_stopclk;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && st_ff.waddr == ADDR_CLK_CTRL && st_ff.wdata[0]
      |=> st_ff.src == 4'h8 && !st_ff.running;
  endproperty
  a_stopclk: assert property (p_stopclk) else $error("Stop clk");

  property p_stream_crc;
    @(posedge aclk) disable iff (!aresetn)
      st_ff.cmd_ctrl[CC_STREAM] && st_ff.ph == ST_DATA |=> !crc_active;
  endproperty
  a_stream_crc: assert property (p_stream_crc) else $error("Crc");

  property p_prg;
    @(posedge aclk) disable iff (!aresetn)
      st_ff.ph == ST_BUSY && $past(st_ff.ph) == ST_BUSY && busy_s
      |=> !($rose(st_ff.src[SRC_PROGRAM_DONE]));
  endproperty
  a_prg: assert property (p_prg) else $error("Prg early");

  property p_wait8;
    @(posedge aclk) disable iff (!aresetn)
      $rose(st_ff.src[SRC_CMD_END]) |-> $past(st_ff.ph) == ST_WAIT &&
      $past(st_ff.cnt) == WAIT_CYC - 8'h01;
  endproperty
  a_wait8: assert property (p_wait8) else $error("Wait count");

  property p_init80;
    @(posedge aclk) disable iff (!aresetn)
      st_ff.ph == ST_INIT ##1 st_ff.ph == ST_CMD |->
      $past(st_ff.cnt, 2) == INIT_CYC - 8'h01;
  endproperty
  a_init80: assert property (p_init80) else $error("Init count");

  property p_fifo_wait;
    @(posedge aclk) disable iff (!aresetn)
      $rose(st_ff.src[SRC_XFER_END]) |-> $past(st_ff.ph) == ST_WAIT &&
      $past(st_ff.cnt) == WAIT_CYC - 8'h01 && st_ff.fifo_rdy;
  endproperty
  a_fifo_wait: assert property (p_fifo_wait) else $error("Fifo wait");

  property p_rd_stop;
    @(posedge aclk) disable iff (!aresetn)
      $rose(st_ff.src[SRC_XFER_END]) && !st_ff.cmd_ctrl[CC_WRITE]
      |-> !st_ff.running;
  endproperty
  a_rd_stop: assert property (p_rd_stop) else $error("Read stop");
endmodule

/* sim/mhi_card_model.sv */
// Card model: holds busy for a while after a CRC block ends while arm is high
module mhi_card_model #(
  parameter int HOLD = 40
) (
  input  wire logic aclk,
  input  wire logic crc_active,
  input  wire logic arm,
  output logic      card_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic crc_q;
  int   left;
  initial begin
    crc_q = 1'b0;
    left = 0;
    card_busy = 1'b0;
  end
  // Busy only follows the end of a CRC block while arm is high; it does not tell a read from a write
  always @(posedge aclk) begin
    crc_q <= crc_active;
    if (arm && crc_q && !crc_active) left <= HOLD;
    else if (left > 0) left <= left - 1;
    card_busy <= (arm && crc_q && !crc_active) || (left > 1);
  end
endmodule

/* sim/tb_mhi_core.sv */
// Testbench for the card host interrupt and sequencing core
module tb_mhi_core
  import mhi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd, rdata;
  logic [1:0]  resp, bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        card_busy, bus_clk, crc_act, irq, arm, saw_crc;
  int          mismatches, checked, cycles, edges, e0, n0, n1, e_irq;
  logic        bclk_q, irq_q;

  mhi_core dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .card_busy(card_busy),
    .card_bus_clock(bus_clk), .crc_active(crc_act),
    .card_host_irq_out(irq));
  mhi_card_model card_u (.aclk(aclk), .crc_active(crc_act), .arm(arm),
    .card_busy(card_busy));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Link clock and irq edges found by sampling on aclk, free of races
  always @(posedge aclk) begin
    cycles++;
    bclk_q <= bus_clk;
    irq_q <= irq;
    if (bus_clk === 1'b1 && bclk_q === 1'b0) edges <= edges + 1;
    if (irq === 1'b1 && irq_q === 1'b0) e_irq <= edges;
    if (crc_act) saw_crc <= 1'b1;
    if (cycles == 50000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Handshakes are sampled mid-cycle so the edge decision is race free
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) break;
    end
    rready <= 1'b0;
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    for (int i = 0; i < 3000; i++) begin
      rdr(a);
      if (rd[b] === v) break;
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic t_reset();
    rdr(ADDR_STATUS);
    chk("status", rd, STATUS_RST);
    rdr(ADDR_INT_SRC);
    chk("sources", rd, 32'h8);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(ADDR_INT_CLEAR, 32'h8);
    rdr(ADDR_INT_SRC);
    chk("clk stop src", rd, 32'h8);
    wr(ADDR_EVENT_IN, 32'h1);
    chk("bad wr", {30'h0, resp}, 32'h2);
    rdr(ADDR_EVENT_IN);
    chk("bad rd", {30'h0, resp}, 32'h2);
    $display("test reset done");
  endtask
  task automatic t_cmd(input logic init, output int n);
    wr(ADDR_INT_EN, 32'h1);
    wr(ADDR_CLK_CTRL, 32'h1);
    wr(ADDR_CMD_CTRL, {25'h0, init, 4'h0, FMT_R1});
    e0 = edges;
    wr(ADDR_CLK_CTRL, 32'h2);
    poll(ADDR_INT_SRC, SRC_CMD_END, 1'b1);
    settle();
    n = e_irq - e0;
    rdr(ADDR_STATUS);
    chk("cmd end", {31'h0, rd[ST_CMD_END]}, 32'h1);
    $display("test command done");
  endtask
  task automatic t_irq();
    wr(ADDR_INT_CLEAR, 32'h0);
    rdr(ADDR_INT_SRC);
    chk("src kept", {31'h0, rd[0]}, 32'h1);
    wr(ADDR_INT_EN, 32'h1);
    settle();
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(ADDR_INT_EN, 32'h0);
    settle();
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(ADDR_INT_EN, 32'h1);
    wr(ADDR_INT_CLEAR, 32'h1);
    settle();
    chk("irq off", {31'h0, irq}, 32'h0);
    rdr(ADDR_INT_SRC);
    chk("src cleared", {31'h0, rd[0]}, 32'h0);
    wr(ADDR_INT_EN, 32'h0);
    $display("test irq done");
  endtask
  task automatic t_blkwr();
    arm <= 1'b1;
    saw_crc <= 1'b0;
    wr(ADDR_CLK_CTRL, 32'h1);
    wr(ADDR_BLK_LEN, 32'h200);
    wr(ADDR_BLK_COUNT, 32'h1);
    wr(ADDR_CMD_CTRL, 32'h0d);
    wr(ADDR_CLK_CTRL, 32'h2);
    poll(ADDR_INT_SRC, SRC_PROGRAM_DONE, 1'b1);
    chk("program_done", {31'h0, rd[SRC_PROGRAM_DONE]}, 32'h1);
    poll(ADDR_INT_SRC, SRC_XFER_END, 1'b1);
    rdr(ADDR_STATUS);
    chk("fifo ready", {31'h0, rd[ST_FIFO_RDY]}, 32'h1);
    chk("block crc", {31'h0, saw_crc}, 32'h1);
    wr(ADDR_CLK_CTRL, 32'h1);
    rdr(ADDR_STATUS);
    chk("status rst", rd, STATUS_RST);
    rdr(ADDR_INT_SRC);
    chk("src rst", rd, 32'h8);
    arm <= 1'b0;
    $display("test block write done");
  endtask
  task automatic t_rdmulti();
    wr(ADDR_BLK_COUNT, 32'h2);
    wr(ADDR_CMD_CTRL, 32'h05);
    wr(ADDR_CLK_CTRL, 32'h2);
    poll(ADDR_INT_SRC, SRC_XFER_END, 1'b1);
    e0 = edges;
    chk("stop src", {31'h0, rd[SRC_CLK_STOP]}, 32'h1);
    rdr(ADDR_STATUS);
    chk("clk stopped", {31'h0, rd[ST_CLK_STOP]}, 32'h1);
    chk("no edges", 32'(edges - e0), 32'h0);
    $display("test multi read done");
  endtask
  task automatic t_stream();
    saw_crc <= 1'b0;
    wr(ADDR_CLK_CTRL, 32'h1);
    wr(ADDR_BLK_COUNT, 32'hffff);
    wr(ADDR_CMD_CTRL, 32'h1d);
    wr(ADDR_CLK_CTRL, 32'h2);
    // Start loads the count; shorten it during the command phase
    wr(ADDR_DATA_LEFT, 32'h8);
    rdr(ADDR_STATUS);
    chk("running", {31'h0, rd[ST_CLK_STOP]}, 32'h0);
    poll(ADDR_STATUS, ST_CLK_STOP, 1'b1);
    rdr(ADDR_DATA_LEFT);
    chk("tail", {31'h0, rd <= 32'(STREAM_TAIL)}, 32'h1);
    chk("no crc", {31'h0, saw_crc}, 32'h0);
    e0 = edges;
    wr(ADDR_CLK_CTRL, 32'h2);
    repeat (20) @(posedge aclk);
    chk("restart", {31'h0, edges > e0}, 32'h1);
    $display("test stream done");
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, arm, saw_crc} = '0;
    {awaddr, araddr, wdata} = '0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_cmd(1'b0, n0);
    t_irq();
    t_cmd(1'b1, n1);
    chk("init clocks", 32'(n1 - n0), 32'h50);
    t_blkwr();
    t_rdmulti();
    t_stream();
    end_sim();
  end
endmodule
